// file: bench/base_src.sv
// partner: 32.768 khz time-base source, still and low while idle
`timescale 1ns/1ns
module base_src #(
    parameter int HALF_NS = 41  // half period, sped up to keep the run short
) (
    // control
    input wire logic run_i,
    // outputs
    output logic clk_o,
    output int edges_o
);
    // square wave only while run_i, rising edges counted for the bench
    initial begin
        clk_o = 1'b0;
        edges_o = 0;
        forever begin
            #HALF_NS;
            if (run_i) begin
                clk_o = ~clk_o;
                edges_o = edges_o + int'(clk_o);
            end else begin
                clk_o = 1'b0;
            end
        end
    end
endmodule : base_src

// file: bench/bcd_clock_calendar_tb_top.sv
// testbench: registers, leap-day rollover, alarm, pin and interrupt of the clock unit
`timescale 1ns/1ns
module bcd_clock_calendar_tb_top;
    import rtc_pkg::*;
    logic clk, rstn, mcr, pin, irq, src, osc_clk, tmr_clk;
    logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp, run;
    int osc_n, tmr_n, err_count, n_checks, cyc;
    // two time-base sources, only the selected one runs
    base_src #(.HALF_NS(41)) u_osc (.run_i(run[0]), .clk_o(osc_clk), .edges_o(osc_n));
    base_src #(.HALF_NS(53)) u_tmr (.run_i(run[1]), .clk_o(tmr_clk), .edges_o(tmr_n));
    bcd_clock_calendar u_dut (
        .sys_clk_i(clk), .rstn_i(rstn), .master_clear_reset_i(mcr), .ce_i(1'b1),
        .secondary_oscillator_i(osc_clk), .timer_clock_input_i(tmr_clk),
        .s_awaddr_i(awaddr), .s_awvalid_i(awvalid), .s_awready_o(awready),
        .s_wdata_i(wdata), .s_wstrb_i(4'hf), .s_wvalid_i(wvalid), .s_wready_o(wready),
        .s_bresp_o(bresp), .s_bvalid_o(bvalid), .s_bready_i(bready),
        .s_araddr_i(araddr), .s_arvalid_i(arvalid), .s_arready_o(arready),
        .s_rdata_o(rdata), .s_rresp_o(rresp), .s_rvalid_o(rvalid), .s_rready_i(rready),
        .alarm_pin_o(pin), .irq_o(irq)
    );
    // 50 mhz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // master clear toggles at random; counting must ignore it
    always @(posedge clk) mcr <= 1'($urandom_range(0, 1));
    // hang guard
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 99000) begin
            err_count = err_count + 1;
            conclude();
        end
    end
    // -------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------
    function automatic logic [7:0] bcd(input int v);
        return 8'((v / 10) * 16 + v % 10);
    endfunction : bcd
    function automatic logic [31:0] tod(input int h, input int m, input int s, input logic hf);
        return {7'h0, bcd(h), bcd(m), bcd(s), hf};
    endfunction : tod
    function automatic logic [31:0] dat(input int y, input int m, input int d, input logic [2:0] w);
        return {5'h0, bcd(y), bcd(m), bcd(d), w};
    endfunction : dat
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks = n_checks + 1;
        if (seen !== exp) begin
            err_count = err_count + 1;
            $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic conclude();
        $display("checks %0d, mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : conclude
    // write: address and data offered together, each released when taken
    task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ad;
        logic wd;
        @(posedge clk);
        ad = 1'b0;
        wd = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(ad && wd)) begin
            @(posedge clk);
            if (awvalid && awready === 1'b1) begin
                ad = 1'b1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready === 1'b1) begin
                wd = 1'b1;
                wvalid <= 1'b0;
            end
        end
        while (bvalid !== 1'b1) @(posedge clk);
        r = bresp;
        bready <= 1'b0;
    endtask : axw
    // read: address held until taken, data taken with rvalid
    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge clk);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : axr
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        axw(a, d, r);
        chk(32'(r), 32'(RESP_OK));
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        axr(a, d, r);
        chk(d, e);
    endtask : rdc
    // -------------------------------------------------------------
    // main sequence
    // -------------------------------------------------------------
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        int n;
        void'($urandom(29));
        {rstn, mcr, awvalid, wvalid, bready, arvalid, rready} = 7'h0;
        {awaddr, araddr, wdata, run} = 50'h0;
        {err_count, n_checks, cyc} = 96'h0;
        src = 1'($urandom_range(0, 1));
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        rdc(OFF_CTRL, CTRL_RST);
        rdc(OFF_TIME, tod(0, 0, 0, 1'b0));
        rdc(OFF_DATE, dat(0, 1, 1, RST_WDAY));
        // unmapped place answers with an error and reads zero
        axw(8'h24, 32'hffff_ffff, r);
        chk(32'(r), 32'(RESP_SLVERR));
        axr(8'h24, d, r);
        chk(d | 32'(r), 32'(RESP_SLVERR));
        // random alarm time read back
        d = tod($urandom_range(0, 23), $urandom_range(0, 59), $urandom_range(0, 59), 1'b1);
        wr(OFF_ALTIME, d);
        rdc(OFF_ALTIME, d);
        // last half second of a leap february 28th, alarm every half step
        wr(OFF_TIME, tod(23, 59, 59, 1'b1));
        wr(OFF_DATE, dat(0, 2, 28, 3'h1));
        wr(OFF_CAL, 32'h0000_007f);
        wr(OFF_ALCFG, {21'h0, AMASK_HALF, 8'h01});
        wr(OFF_IRQMASK, 32'h0000_0007);
        wr(OFF_CTRL, 32'(1 << CTRL_EN | 32'(src) << CTRL_SRC | 1 << CTRL_OUTEN | 1 << CTRL_ALEN));
        chk(32'(pin), 32'h0);
        run[src] <= 1'b1;
        while (pin !== 1'b1) @(posedge clk);
        run <= 2'b00;
        n = src ? tmr_n : osc_n;
        chk(32'(n >= 16256 && n <= 16258), 32'h1);
        rdc(OFF_TIME, tod(0, 0, 0, 1'b0));
        rdc(OFF_DATE, dat(0, 2, 29, 3'h2));
        chk(32'(irq), 32'h1);
        wr(OFF_IRQMASK, 32'h0);
        repeat (3) @(posedge clk);
        chk(32'(irq), 32'h0);
        wr(OFF_IRQMASK, 32'h7);
        repeat (3) @(posedge clk);
        chk(32'(irq), 32'h1);
        rdc(OFF_STATUS, 32'h7);
        rdc(OFF_STATUS, 32'h0);
        chk(32'(irq), 32'h0);
        wr(OFF_CTRL, 32'h1);
        repeat (3) @(posedge clk);
        chk(32'(pin), 32'h0);
        conclude();
    end
endmodule : bcd_clock_calendar_tb_top

// file: rtl/bcd_clock_calendar.sv
// bcd clock and calendar with alarm, tick pin, calibration and axi-lite registers
// Summary of operation
// - count hours, minutes, seconds and half seconds
// - hours run in 24-hour form
// - keep day, month and year counts
// - hardware weekday and leap years, 2000-2099
// - seconds, minutes, hours, day, month and year held in bcd digits
// - configurable alarm with repeat, flags on match
// - output pin carries alarm or second tick
// - time base from oscillator or timer input
// - calibration value trims the half-second divider
// - counting runs on through master clear reset
`timescale 1ns/1ns
module bcd_clock_calendar (
    // clock, reset, enable
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic master_clear_reset_i,
    input wire logic ce_i,
    // 32.768 khz time-base pins
    input wire logic secondary_oscillator_i,
    input wire logic timer_clock_input_i,
    // axi4-lite write
    input wire logic [7:0] s_awaddr_i,
    input wire logic s_awvalid_i,
    output logic s_awready_o,
    input wire logic [31:0] s_wdata_i,
    input wire logic [3:0] s_wstrb_i,
    input wire logic s_wvalid_i,
    output logic s_wready_o,
    output logic [1:0] s_bresp_o,
    output logic s_bvalid_o,
    input wire logic s_bready_i,
    // axi4-lite read
    input wire logic [7:0] s_araddr_i,
    input wire logic s_arvalid_i,
    output logic s_arready_o,
    output logic [31:0] s_rdata_o,
    output logic [1:0] s_rresp_o,
    output logic s_rvalid_o,
    input wire logic s_rready_i,
    // outputs
    output logic alarm_pin_o,
    output logic irq_o
);
    import rtc_pkg::*;

    // ------------------------------------------------------------
    // time-base synchroniser and edge detect
    // ------------------------------------------------------------
    logic [1:0] osc_sync, tck_sync;   // two-stage synchronisers
    logic base_d;                     // previous selected level
    logic base_rise;                  // one base edge seen
    logic [31:0] ctrl;                // control register
    always_comb begin
        base_rise = (ctrl[CTRL_SRC] ? tck_sync[1] : osc_sync[1]) & ~base_d;
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    tod_t tod, next_tod;             // time of day
    cal_t cal, next_cal;             // calendar
    tod_t al_tod;                    // alarm time
    cal_t al_cal;                    // alarm date
    logic [2:0] al_mask;             // alarm match mask
    logic [7:0] al_rpt;              // remaining repeats
    logic [7:0] cal_val;             // signed calibration, base edges per half
    logic [14:0] div, next_div;      // half-second divider
    logic half_tick;                 // one half-second step
    logic [ST_W-1:0] status, irq_mask;
    logic pin;                       // pin level before registering

    // ------------------------------------------------------------
    // divider with calibration
    // ------------------------------------------------------------
    logic [14:0] div_last;
    always_comb begin
        // signed trim shortens or lengthens each half second
        div_last = HALF_LAST - 15'({{7{cal_val[7]}}, cal_val});
        half_tick = ctrl[CTRL_EN] && base_rise && (div == div_last);
        if (!ctrl[CTRL_EN]) begin
            next_div = div;
        end else if (base_rise) begin
            next_div = (div == div_last) ? 15'h0000 : div + 15'h0001;
        end else begin
            next_div = div;
        end
    end

    // ------------------------------------------------------------
    // bcd counter chain
    // ------------------------------------------------------------
    logic [7:0] sec_n, min_n, hour_n, day_n, mon_n, year_n;
    logic sec_w, min_w, hour_w, day_w, mon_w;
    logic [7:0] mdays;               // last day of current month
    logic leap;
    // 2000-2099: leap when the bcd year is divisible by four
    always_comb begin
        leap = (cal.year[4] ? (cal.year[1:0] == 2'h2) : (cal.year[1:0] == 2'h0));
        unique case (cal.mon)
            8'h02: mdays = leap ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: mdays = 8'h30;
            default: mdays = 8'h31;
        endcase
    end
    bcd_digit_counter u_sec (.val_i(tod.sec), .first_i(8'h00), .last_i(8'h59),
        .next_o(sec_n), .wrap_o(sec_w));
    bcd_digit_counter u_min (.val_i(tod.min), .first_i(8'h00), .last_i(8'h59),
        .next_o(min_n), .wrap_o(min_w));
    bcd_digit_counter u_hour (.val_i(tod.hour), .first_i(8'h00), .last_i(8'h23),
        .next_o(hour_n), .wrap_o(hour_w));
    bcd_digit_counter u_day (.val_i(cal.day), .first_i(8'h01), .last_i(mdays),
        .next_o(day_n), .wrap_o(day_w));
    bcd_digit_counter u_mon (.val_i(cal.mon), .first_i(8'h01), .last_i(8'h12),
        .next_o(mon_n), .wrap_o(mon_w));
    bcd_digit_counter u_year (.val_i(cal.year), .first_i(8'h00), .last_i(8'h99),
        .next_o(year_n), .wrap_o());

    // carry ripple, gated by each lower wrap
    logic sec_step, min_step, hour_step, day_step;
    always_comb begin
        sec_step = half_tick && tod.half;
        min_step = sec_step && sec_w;
        hour_step = min_step && min_w;
        day_step = hour_step && hour_w;
    end

    // ------------------------------------------------------------
    // axi-lite write decode
    // ------------------------------------------------------------
    logic aw_held, w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic do_wr;
    always_comb begin
        do_wr = aw_held && w_held && !s_bvalid_o;
    end

    // ------------------------------------------------------------
    // time and calendar next state
    // ------------------------------------------------------------
    always_comb begin
        next_tod = tod;
        next_cal = cal;
        if (half_tick) begin
            next_tod.half = ~tod.half;
        end
        if (sec_step) next_tod.sec = sec_n;
        if (min_step) next_tod.min = min_n;
        if (hour_step) next_tod.hour = hour_n;
        if (day_step) begin
            next_cal.day = day_n;
            next_cal.wday = (cal.wday == 3'h6) ? 3'h0 : cal.wday + 3'h1;
            if (day_w) begin
                next_cal.mon = mon_n;
                if (mon_w) next_cal.year = year_n;
            end
        end
        // software writes override the count
        if (do_wr && aw_addr == OFF_TIME) begin
            next_tod = tod_t'(w_data[24:0]);
        end
        if (do_wr && aw_addr == OFF_DATE) begin
            next_cal = cal_t'(w_data[26:0]);
        end
    end

    // ------------------------------------------------------------
    // alarm match
    // ------------------------------------------------------------
    logic match, al_fire;
    logic half_d;                    // one cycle after a half step
    always_comb begin
        unique case (al_mask)
            AMASK_HALF: match = 1'b1;
            AMASK_SEC: match = tod.half == 1'b0;
            AMASK_MIN: match = tod.sec == al_tod.sec;
            AMASK_HOUR: match = tod[16:0] == al_tod[16:0];
            AMASK_DAY: match = tod[24:1] == al_tod[24:1];
            AMASK_WEEK: match = tod[24:1] == al_tod[24:1] && cal.wday == al_cal.wday;
            AMASK_MONTH: match = tod[24:1] == al_tod[24:1] && cal.day == al_cal.day;
            AMASK_YEAR: match = tod[24:1] == al_tod[24:1] && cal[18:3] == al_cal[18:3];
        endcase
        // the check runs on each new half-second state
        al_fire = ctrl[CTRL_ALEN] && half_d && match;
    end

    // ------------------------------------------------------------
    // registered state: only master_clear_reset-independent reset
    // ------------------------------------------------------------
    // the counting state ignores master clear; only rstn_i (power-on) resets it
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            osc_sync <= 2'h0;
            tck_sync <= 2'h0;
            base_d <= 1'b0;
            div <= 15'h0000;
            tod <= '0;
            cal <= {8'h00, RST_MON, RST_DAY, RST_WDAY};
            half_d <= 1'b0;
        end else if (ce_i) begin
            osc_sync <= {osc_sync[0], secondary_oscillator_i};
            tck_sync <= {tck_sync[0], timer_clock_input_i};
            base_d <= ctrl[CTRL_SRC] ? tck_sync[1] : osc_sync[1];
            div <= next_div;
            tod <= next_tod;
            cal <= next_cal;
            half_d <= half_tick;
        end
    end

    // ------------------------------------------------------------
    // register file and bus slave
    // ------------------------------------------------------------
    logic do_rd, rd_status;
    logic [31:0] rd_word;
    logic [7:0] next_rpt;
    logic [ST_W-1:0] next_status, ev;
    always_comb begin
        do_rd = s_arvalid_i && !s_rvalid_o;
        rd_status = do_rd && s_araddr_i == OFF_STATUS;
        unique case (s_araddr_i)
            OFF_CTRL: rd_word = ctrl;
            OFF_TIME: rd_word = {7'h00, tod};
            OFF_DATE: rd_word = {5'h00, cal};
            OFF_ALTIME: rd_word = {7'h00, al_tod};
            OFF_ALDATE: rd_word = {5'h00, al_cal};
            OFF_ALCFG: rd_word = {21'h000000, al_mask, al_rpt};
            OFF_CAL: rd_word = {24'h000000, cal_val};
            OFF_STATUS: rd_word = {29'h00000000, status};
            OFF_IRQMASK: rd_word = {29'h00000000, irq_mask};
            default: rd_word = 32'h0000_0000;
        endcase
        ev = '0;
        ev[ST_ALARM] = al_fire;
        ev[ST_SEC] = sec_step;
        ev[ST_DAY] = day_step;
        // a new event wins over the read clear
        next_status = (rd_status ? '0 : status) | ev;
        // repeat count falls each alarm; chime keeps it going
        next_rpt = al_rpt;
        if (al_fire && al_rpt != 8'h00) next_rpt = al_rpt - 8'h01;
    end

    logic wr_ok, rd_ok;
    always_comb begin
        wr_ok = aw_addr <= OFF_IRQMASK && aw_addr[1:0] == 2'h0;
        rd_ok = s_araddr_i <= OFF_IRQMASK && s_araddr_i[1:0] == 2'h0;
    end

    // register storage: reset by power-on reset only; master clear is not used
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            ctrl <= CTRL_RST;
            al_tod <= '0;
            al_cal <= '0;
            al_mask <= AMASK_HALF;
            al_rpt <= 8'h00;
            cal_val <= 8'h00;
            status <= '0;
            irq_mask <= '0;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            s_bvalid_o <= 1'b0;
            s_bresp_o <= RESP_OK;
            s_rvalid_o <= 1'b0;
            s_rresp_o <= RESP_OK;
            s_rdata_o <= 32'h0000_0000;
            irq_o <= 1'b0;
            pin <= 1'b0;
            alarm_pin_o <= 1'b0;
        end else if (ce_i) begin
            status <= next_status;
            al_rpt <= next_rpt;
            // alarm disables itself on a fire with no repeats left, unless chime is set
            if (al_fire && al_rpt == 8'h00 && !ctrl[CTRL_CHIME]) ctrl[CTRL_ALEN] <= 1'b0;
            if (s_awvalid_i && !aw_held) begin
                aw_held <= 1'b1;
                aw_addr <= s_awaddr_i;
            end
            if (s_wvalid_i && !w_held) begin
                w_held <= 1'b1;
                w_data <= s_wdata_i;
            end
            if (do_wr) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_bvalid_o <= 1'b1;
                s_bresp_o <= wr_ok ? RESP_OK : RESP_SLVERR;
                unique case (aw_addr)
                    OFF_CTRL: ctrl <= {26'h0000000, w_data[5:0]};
                    OFF_ALTIME: al_tod <= tod_t'(w_data[24:0]);
                    OFF_ALDATE: al_cal <= cal_t'(w_data[26:0]);
                    OFF_ALCFG: begin
                        al_mask <= w_data[10:8];
                        al_rpt <= w_data[7:0];
                    end
                    OFF_CAL: cal_val <= w_data[7:0];
                    OFF_IRQMASK: irq_mask <= w_data[ST_W-1:0];
                    default: ;
                endcase
            end else if (s_bvalid_o && s_bready_i) begin
                s_bvalid_o <= 1'b0;
            end
            if (do_rd) begin
                s_rvalid_o <= 1'b1;
                s_rdata_o <= rd_word;
                s_rresp_o <= rd_ok ? RESP_OK : RESP_SLVERR;
            end else if (s_rvalid_o && s_rready_i) begin
                s_rvalid_o <= 1'b0;
            end
            irq_o <= |(next_status & irq_mask);
            // pin: alarm toggles, or second tick, when enabled
            if (!ctrl[CTRL_OUTEN]) pin <= 1'b0;
            else if (ctrl[CTRL_OUTSEL]) pin <= ~tod.half;
            else if (al_fire) pin <= ~pin;
            alarm_pin_o <= pin;
        end
    end

    always_comb begin
        s_awready_o = !aw_held;
        s_wready_o = !w_held;
        s_arready_o = !s_rvalid_o;
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);
    a_half_flip: assert property (ce_i && half_tick && !do_wr |=> tod.half != $past(tod.half))
        else $error("half step missing");
    a_hour_range: assert property (tod.hour <= 8'h23)
        else $error("hour above 23");
    a_day_range: assert property (cal.day != 8'h00 && cal.day <= 8'h31)
        else $error("day out of range");
    a_feb_leap: assert property (ce_i && day_step && cal.mon == 8'h02 && cal.day == 8'h28
        && (cal.year == 8'h00 || cal.year == 8'h24) && !do_wr |=> cal.day == 8'h29)
        else $error("leap february wrong");
    a_bcd_digits: assert property (tod.sec[3:0] <= 4'h9 && tod.min[3:0] <= 4'h9)
        else $error("non-bcd digit");
    a_alarm_flag: assert property (ce_i && al_fire |=> status[ST_ALARM])
        else $error("alarm not flagged");
    a_pin_off: assert property (ce_i && !ctrl[CTRL_OUTEN] |=> ##1 !alarm_pin_o)
        else $error("pin active while off");
    a_min_carry: assert property (ce_i && min_step && !do_wr |=> tod.sec == 8'h00)
        else $error("second carry wrong");
    a_master_clear_reset_runs: assert property (master_clear_reset_i && ce_i && half_tick && !do_wr
        |=> tod.half != $past(tod.half))
        else $error("stopped under master clear");
endmodule : bcd_clock_calendar

// file: rtl/bcd_digit_counter.sv
// bcd counter: two-digit decimal count with programmable wrap
`timescale 1ns/1ns
module bcd_digit_counter (
    // current value and limits
    input wire logic [7:0] val_i,
    input wire logic [7:0] first_i,
    input wire logic [7:0] last_i,
    // results
    output logic [7:0] next_o,
    output logic wrap_o
);
    // ----------------------------------------
    // increment one bcd pair
    // ----------------------------------------
    always_comb begin
        wrap_o = (val_i == last_i);
        if (wrap_o) begin
            next_o = first_i;
        end else if (val_i[3:0] == 4'h9) begin
            // carry into the tens digit
            next_o = {val_i[7:4] + 4'h1, 4'h0};
        end else begin
            next_o = {val_i[7:4], val_i[3:0] + 4'h1};
        end
    end
endmodule : bcd_digit_counter

// file: rtl/rtc_pkg.sv
// package: register map, field layouts, reset values and timing counts of the clock unit
package rtc_pkg;
    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL = 8'h00;     // control
    localparam logic [7:0] OFF_TIME = 8'h04;     // hours/minutes/seconds/half
    localparam logic [7:0] OFF_DATE = 8'h08;     // year/month/day/weekday
    localparam logic [7:0] OFF_ALTIME = 8'h0c;   // alarm hours/minutes/seconds
    localparam logic [7:0] OFF_ALDATE = 8'h10;   // alarm month/day/weekday
    localparam logic [7:0] OFF_ALCFG = 8'h14;    // alarm mask and repeat count
    localparam logic [7:0] OFF_CAL = 8'h18;      // calibration value
    localparam logic [7:0] OFF_STATUS = 8'h1c;   // sticky events, read clears
    localparam logic [7:0] OFF_IRQMASK = 8'h20;  // interrupt enable mask
    // ------------------------------------------------------------
    // control fields
    // ------------------------------------------------------------
    localparam int CTRL_EN = 0;        // counting enable
    localparam int CTRL_SRC = 1;       // time base: 0 oscillator, 1 timer clock input
    localparam int CTRL_OUTEN = 2;     // output pin enable
    localparam int CTRL_OUTSEL = 3;    // 0 alarm, 1 seconds tick
    localparam int CTRL_ALEN = 4;      // alarm enable
    localparam int CTRL_CHIME = 5;     // repeat forever
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    // ------------------------------------------------------------
    // alarm mask codes (which fields must match)
    // ------------------------------------------------------------
    localparam logic [2:0] AMASK_HALF = 3'h0;   // every half second
    localparam logic [2:0] AMASK_SEC = 3'h1;    // every second
    localparam logic [2:0] AMASK_MIN = 3'h2;    // seconds match
    localparam logic [2:0] AMASK_HOUR = 3'h3;   // minutes, seconds and half
    localparam logic [2:0] AMASK_DAY = 3'h4;    // full time match
    localparam logic [2:0] AMASK_WEEK = 3'h5;   // weekday and time
    localparam logic [2:0] AMASK_MONTH = 3'h6;  // day and time
    localparam logic [2:0] AMASK_YEAR = 3'h7;   // month, day and time
    // ------------------------------------------------------------
    // status bits
    // ------------------------------------------------------------
    localparam int ST_ALARM = 0;   // alarm reached
    localparam int ST_SEC = 1;     // second tick
    localparam int ST_DAY = 2;     // day rollover
    localparam int ST_W = 3;       // status width
    // ------------------------------------------------------------
    // time base
    // ------------------------------------------------------------
    localparam int BASE_HZ = 32768;              // external time-base frequency
    localparam int HALF_DIV = BASE_HZ / 2;       // base edges per half second
    localparam logic [14:0] HALF_LAST = 15'(HALF_DIV - 1);
    localparam logic [7:0] RST_DAY = 8'h01;      // reset date 2000-01-01
    localparam logic [7:0] RST_MON = 8'h01;
    localparam logic [2:0] RST_WDAY = 3'h6;      // 2000-01-01 was a saturday
    // ------------------------------------------------------------
    // packed carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] hour;
        logic [7:0] min;
        logic [7:0] sec;
        logic half;
    } tod_t;
    typedef struct packed {
        logic [7:0] year;
        logic [7:0] mon;
        logic [7:0] day;
        logic [2:0] wday;
    } cal_t;
    // axi-lite answer
    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : rtc_pkg
